/* File: core/asf_pkg.sv */
/*
  Package for the ALU status flag and addressing block: flag field layout,
  operation codes, addressing modes and carrier structs.
  Assumes a single core clock and a synchronous active-low reset.
*/
package asf_pkg;

  // ----------------------------------------------------------------
  // flag layout
  // ----------------------------------------------------------------
  localparam int          ASF_W        = 8;
  localparam int          ASF_C_BIT    = 0;
  localparam int          ASF_DC_BIT   = 1;
  localparam int          ASF_Z_BIT    = 2;
  localparam int          ASF_OV_BIT   = 3;
  localparam int          ASF_N_BIT    = 4;
  localparam int          ASF_MSB      = 7;
  localparam int          ASF_NIB      = 4;
  localparam logic [7:0]  ASF_IMPL_MSK = 8'h1F;
  localparam logic [4:0]  ASF_FLAG_RST = 5'h00;
  localparam logic [7:0]  ASF_ZERO8    = 8'h00;
  localparam logic [11:0] ASF_ADDR_RST = 12'h000;

  // ----------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ASF_OP_NONE     = 4'h0,
    ASF_OP_ADD_WF   = 4'h1,  // add_work_file_op
    ASF_OP_ADD_LIT  = 4'h2,  // add_literal_op
    ASF_OP_SUB_LIT  = 4'h3,  // sub_from_literal_op
    ASF_OP_SUB_WF   = 4'h4,  // sub_work_file_op
    ASF_OP_AND      = 4'h5,
    ASF_OP_OR       = 4'h6,
    ASF_OP_XOR      = 4'h7,
    ASF_OP_CLEAR    = 4'h8,  // clear_file_op
    ASF_OP_BIT_CLR  = 4'h9,  // bit_clear_op
    ASF_OP_BIT_SET  = 4'hA,  // bit_set_op
    ASF_OP_SWAP     = 4'hB,  // nibble_swap_op
    ASF_OP_MOVE_FF  = 4'hC,  // file_to_file_move_op
    ASF_OP_MOVE_WF  = 4'hD   // work_to_file_move_op
  } asf_op_t;

  // ----------------------------------------------------------------
  // addressing modes, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ASF_AM_INHERENT = 5'h01,
    ASF_AM_LITERAL  = 5'h02,
    ASF_AM_DIRECT   = 5'h04,
    ASF_AM_INDIRECT = 5'h08,
    ASF_AM_INDEXED  = 5'h10
  } asf_mode_t;

  // operand request from the decoder
  typedef struct packed {
    logic       valid;
    asf_op_t    op;
    logic [7:0] a;          // file or working operand
    logic [7:0] b;          // second operand (working or literal)
    logic [2:0] bit_sel;    // for bit clear/set
    logic       dest_flags; // destination is the flag register
    logic       has_lit;    // operand form carries a literal
    logic       use_ptr;    // operand names an indirect pointer
    logic       access;     // access-bank form
    logic [7:0] faddr;      // file address byte / offset
    logic [11:0] ptr;       // pointer value
    logic [3:0] bank;
  } asf_req_t;

  // registered result and addressing outcome
  typedef struct packed {
    logic       valid;
    logic [7:0] result;
    asf_mode_t  mode;
    logic [11:0] addr;
  } asf_rsp_t;

  typedef struct packed {
    logic [4:0] flags;
    asf_rsp_t   rsp;
  } asf_state_t;

endpackage

/* File: core/asf_core.sv */
/*
  ALU status flags and data addressing mode selection.
  Operands arrive from the core's decoder on the same clock; the extended
  instruction set enable is a configuration level from the same domain.
*/
`timescale 1ns/10ps
module asf_core (
  // clock and reset
  input  wire logic            sys_clk_in,
  input  wire logic            rst_b_in,
  // configuration
  input  wire logic            extended_isa_enable_in,
  // operation in
  input  wire asf_pkg::asf_req_t req_in,
  // flag register read port
  output logic [7:0]           alu_flag_register_out,
  // result out
  output asf_pkg::asf_rsp_t    rsp_out
);
  import asf_pkg::*;

  // ----------------------------------------------------------------
  // combinational datapath
  // ----------------------------------------------------------------
  asf_state_t s_q;
  asf_state_t s_d;

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] opx;
  logic [7:0] opy;
  logic [7:0] res;
  logic       arith;
  logic       logic_op;
  logic       sub;
  logic       writes_file;
  logic [4:0] f;

  always_comb
  begin
    sub   = (req_in.op == ASF_OP_SUB_LIT) || (req_in.op == ASF_OP_SUB_WF);
    arith = (req_in.op == ASF_OP_ADD_WF) || (req_in.op == ASF_OP_ADD_LIT) || sub;
    logic_op = (req_in.op == ASF_OP_AND) || (req_in.op == ASF_OP_OR) ||
               (req_in.op == ASF_OP_XOR) || (req_in.op == ASF_OP_CLEAR);
    // subtract = minuend + ~subtrahend + 1, so carries read as not-borrow
    opx = req_in.a;
    opy = sub ? ~req_in.b : req_in.b;
    if (req_in.op == ASF_OP_SUB_LIT)
    begin
      opx = req_in.b;
      opy = ~req_in.a;
    end
    sum = {1'b0, opx} + {1'b0, opy} + {8'h00, sub};
    nib = {1'b0, opx[ASF_NIB-1:0]} + {1'b0, opy[ASF_NIB-1:0]} + {4'h0, sub};

    res = sum[ASF_MSB:0];
    writes_file = 1'b0;
    case (req_in.op)
      ASF_OP_AND:     res = req_in.a & req_in.b;
      ASF_OP_OR:      res = req_in.a | req_in.b;
      ASF_OP_XOR:     res = req_in.a ^ req_in.b;
      ASF_OP_CLEAR:   res = ASF_ZERO8;
      ASF_OP_BIT_CLR:
      begin
        res = req_in.a & ~(8'h01 << req_in.bit_sel);
        writes_file = 1'b1;
      end
      ASF_OP_BIT_SET:
      begin
        res = req_in.a | (8'h01 << req_in.bit_sel);
        writes_file = 1'b1;
      end
      ASF_OP_SWAP:
      begin
        res = {req_in.a[3:0], req_in.a[7:4]};
        writes_file = 1'b1;
      end
      ASF_OP_MOVE_FF,
      ASF_OP_MOVE_WF:
      begin
        res = req_in.a;
        writes_file = 1'b1;
      end
      default:        res = sum[ASF_MSB:0];
    endcase

    // flag update from the alu
    f = s_q.flags;
    if (arith || logic_op)
    begin
      f[ASF_Z_BIT] = (res == ASF_ZERO8);
      // clear owns only the zero flag, so a cleared flag register keeps n
      if (req_in.op != ASF_OP_CLEAR)
        f[ASF_N_BIT] = res[ASF_MSB];
    end
    if (arith)
    begin
      f[ASF_C_BIT]  = sum[ASF_W];
      f[ASF_DC_BIT] = nib[ASF_NIB];
      f[ASF_OV_BIT] = (opx[ASF_MSB] == opy[ASF_MSB]) &&
                      (res[ASF_MSB] != opx[ASF_MSB]);
    end
    // a flag-affecting op aimed at the flags never stores its result there;
    // only the alu flag logic above lands, so clear sets zero and keeps the other flags
    if (req_in.dest_flags && writes_file)
      f = res[ASF_N_BIT:0];

    s_d = s_q;
    s_d.rsp.valid = req_in.valid;
    if (req_in.valid)
    begin
      s_d.flags      = f;
      s_d.rsp.result = res;
      // addressing: program side uses the counter only, not handled here
      if (!req_in.use_ptr && !req_in.has_lit && req_in.faddr == ASF_ZERO8 &&
          req_in.op == ASF_OP_NONE)
        s_d.rsp.mode = ASF_AM_INHERENT;
      else if (req_in.has_lit && !req_in.access)
        s_d.rsp.mode = ASF_AM_LITERAL;
      else if (req_in.use_ptr)
        s_d.rsp.mode = ASF_AM_INDIRECT;
      else if (extended_isa_enable_in && req_in.access && req_in.has_lit)
        s_d.rsp.mode = ASF_AM_INDEXED;
      else
        s_d.rsp.mode = ASF_AM_DIRECT;
      case (s_d.rsp.mode)
        ASF_AM_INDIRECT: s_d.rsp.addr = req_in.ptr;
        ASF_AM_INDEXED:  s_d.rsp.addr = req_in.ptr + {4'h0, req_in.faddr};
        ASF_AM_DIRECT:   s_d.rsp.addr = {req_in.bank, req_in.faddr};
        default:         s_d.rsp.addr = ASF_ADDR_RST;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      s_q.flags      <= ASF_FLAG_RST;
      s_q.rsp.valid  <= 1'b0;
      s_q.rsp.result <= ASF_ZERO8;
      s_q.rsp.mode   <= ASF_AM_INHERENT;
      s_q.rsp.addr   <= ASF_ADDR_RST;
    end
    else
      s_q <= s_d;
  end

  // unimplemented upper bits always read as zero
  assign alu_flag_register_out = {3'b000, s_q.flags} & ASF_IMPL_MSK;
  assign rsp_out               = s_q.rsp;

endmodule

/* File: bench/asf_core_chk.sv */
/* checker: flag and addressing properties on the asf_core ports
   assumes one clock, sync active-low reset; bound below */
`timescale 1ns/10ps
module asf_core_chk
  import asf_pkg::*;
(
  input wire logic       sys_clk_in,
  input wire logic       rst_b_in,
  input wire logic       extended_isa_enable_in,
  input wire asf_req_t   req_in,
  input wire logic [7:0] alu_flag_register_out,
  input wire asf_rsp_t   rsp_out
);
  // ----
  // helpers
  // ----
  logic [8:0] sum;
  logic [8:0] dif;
  logic [4:0] hs;
  logic [4:0] f;
  logic       ovf;
  logic       go;
  logic       logic_op;
  assign sum = req_in.a + req_in.b;
  assign dif = {1'b0, req_in.a} + {1'b0, ~req_in.b} + 9'h001;
  assign hs = req_in.a[3:0] + req_in.b[3:0];
  assign f = alu_flag_register_out[4:0];
  assign ovf = (req_in.a[7] == req_in.b[7]) && (sum[7] != req_in.a[7]);
  assign go = req_in.valid && (req_in.op == ASF_OP_ADD_WF);
  assign logic_op = req_in.valid && (req_in.op inside {[ASF_OP_ADD_WF:ASF_OP_XOR]});
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // ----
  // properties
  // ----
  property p_hi; alu_flag_register_out[7:5] == 3'h0; endproperty
  property p_c; go |=> rsp_out.result == $past(sum[7:0]) && f[0] == $past(sum[8]); endproperty
  property p_dc; go |=> f[1] == $past(hs[4]); endproperty
  property p_ov; go |=> f[3] == $past(ovf); endproperty
  property p_sub; req_in.valid && req_in.op == ASF_OP_SUB_WF
    |=> rsp_out.result == $past(dif[7:0]) && f[0] == $past(dif[8]); endproperty
  property p_n; logic_op |=> f[4] == rsp_out.result[7]; endproperty
  property p_z; logic_op |=> f[2] == (rsp_out.result == 8'h00); endproperty
  property p_clr; req_in.valid && req_in.op == ASF_OP_CLEAR && req_in.dest_flags
    |=> alu_flag_register_out == ($past(alu_flag_register_out) | 8'h04); endproperty
  property p_mov; req_in.valid && req_in.op == ASF_OP_MOVE_WF && req_in.dest_flags
    |=> f == rsp_out.result[4:0]; endproperty
  property p_idx; req_in.valid && req_in.access && req_in.has_lit && !req_in.use_ptr
    |=> (rsp_out.mode == ASF_AM_INDEXED) == $past(extended_isa_enable_in); endproperty
  a_hi: assert property (p_hi) else $error("upper flag bits set");
  a_c: assert property (p_c) else $error("add carry wrong");
  a_dc: assert property (p_dc) else $error("half carry wrong");
  a_ov: assert property (p_ov) else $error("overflow wrong");
  a_sub: assert property (p_sub) else $error("subtract borrow wrong");
  a_n: assert property (p_n) else $error("negative wrong");
  a_z: assert property (p_z) else $error("zero wrong");
  a_clr: assert property (p_clr) else $error("clear of flags wrong");
  a_mov: assert property (p_mov) else $error("flag store wrong");
  a_idx: assert property (p_idx) else $error("indexed mode gating");
  c_borrow: cover property (req_in.valid && req_in.op == ASF_OP_SUB_WF ##1 !f[0]);
  c_clr: cover property (req_in.valid && req_in.op == ASF_OP_CLEAR && req_in.dest_flags);
  c_idx: cover property (rsp_out.mode == ASF_AM_INDEXED);
  c_mov: cover property (req_in.valid && req_in.op == ASF_OP_MOVE_WF && req_in.dest_flags);
  c_ovf: cover property (go ##1 f[3]);
endmodule
bind asf_core asf_core_chk asf_core_chk_inst (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
  .extended_isa_enable_in(extended_isa_enable_in), .req_in(req_in),
  .alu_flag_register_out(alu_flag_register_out), .rsp_out(rsp_out));

/* File: bench/asf_core_tb_top.sv */
/* bench: random requests of every operation except none, and every operand form, expected queue
   compared on each response; assumes core files compiled first */
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module asf_core_tb_top;
  import asf_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        ext = 1'b0;
  asf_req_t    req = '0;
  logic [7:0]  flag_out;
  asf_rsp_t    rsp;
  asf_state_t  exp_q[$];
  asf_state_t  ed;
  asf_state_t  em;
  logic [63:0] r;
  logic [4:0]  fm = 5'h00;
  int          seed = 32'h908E5AB1;
  int          bad_count = 0;
  int          tests_run = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  asf_core asf_core_inst (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .extended_isa_enable_in(ext), .req_in(req), .alu_flag_register_out(flag_out),
    .rsp_out(rsp));
  // ----
  // reference: subtract adds the complement plus one
  // ----
  function automatic asf_state_t model(asf_req_t q, logic xe, logic [4:0] fo);
    asf_state_t e;
    logic [7:0] x;
    logic [7:0] y;
    logic [8:0] s;
    logic [4:0] h;
    logic       sb;
    e = '0;
    e.flags = fo;
    e.rsp.valid = 1'b1;
    sb = (q.op == ASF_OP_SUB_WF) || (q.op == ASF_OP_SUB_LIT);
    x = (q.op == ASF_OP_SUB_LIT) ? q.b : q.a;
    y = (q.op == ASF_OP_SUB_LIT) ? q.a : q.b;
    y = sb ? ~y : y;
    s = {1'b0, x} + {1'b0, y} + {8'h00, sb};
    h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, sb};
    case (q.op)
      ASF_OP_AND:     e.rsp.result = q.a & q.b;
      ASF_OP_OR:      e.rsp.result = q.a | q.b;
      ASF_OP_XOR:     e.rsp.result = q.a ^ q.b;
      ASF_OP_CLEAR:   e.rsp.result = 8'h00;
      ASF_OP_BIT_CLR: e.rsp.result = q.a & ~(8'h01 << q.bit_sel);
      ASF_OP_BIT_SET: e.rsp.result = q.a | (8'h01 << q.bit_sel);
      ASF_OP_SWAP:    e.rsp.result = {q.a[3:0], q.a[7:4]};
      ASF_OP_MOVE_FF,
      ASF_OP_MOVE_WF: e.rsp.result = q.a;
      default:        e.rsp.result = s[7:0];
    endcase
    if (q.op inside {[ASF_OP_ADD_WF:ASF_OP_SUB_WF]})
      e.flags = {s[7], (x[7] == y[7]) && (s[7] != x[7]), s[7:0] == 8'h00, h[4], s[8]};
    else if (q.op inside {[ASF_OP_AND:ASF_OP_XOR]})
      e.flags = {e.rsp.result[7], fo[3], e.rsp.result == 8'h00, fo[1:0]};
    else if (q.op == ASF_OP_CLEAR)
      e.flags = fo | 5'h04;
    else if (q.dest_flags)
      e.flags = e.rsp.result[4:0];
    if (q.has_lit && !q.access)
      e.rsp.mode = ASF_AM_LITERAL;
    else if (q.use_ptr)
    begin
      e.rsp.mode = ASF_AM_INDIRECT;
      e.rsp.addr = q.ptr;
    end
    else if (xe && q.access && q.has_lit)
    begin
      e.rsp.mode = ASF_AM_INDEXED;
      e.rsp.addr = q.ptr + {4'h0, q.faddr};
    end
    else
    begin
      e.rsp.mode = ASF_AM_DIRECT;
      e.rsp.addr = {q.bank, q.faddr};
    end
    return e;
  endfunction
  task automatic results();
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----
  // driver: mixed idle and back-to-back requests
  // ----
  initial
  begin
    repeat (6) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    for (int i = 0; i < 600; i++)
    begin
      @(negedge sys_clk_in);
      r = {$random(seed), $random(seed)};
      req = r[51:0];
      req.valid = r[59] | r[58];
      req.op = asf_op_t'(r[63:60] % 4'hD + 4'h1);
      // clear mostly aimed at the flag register, which keeps the flags it does not own
      if (req.op == ASF_OP_CLEAR)
        req.dest_flags = r[57] | r[56];
      ext = r[52];
      if (req.valid)
      begin
        ed = model(req, ext, fm);
        fm = ed.flags;
        exp_q.push_back(ed);
      end
    end
    @(negedge sys_clk_in);
    req.valid = 1'b0;
    for (int k = 0; k < 20 && exp_q.size() > 0; k++)
      @(negedge sys_clk_in);
    if (exp_q.size() != 0)
      bad_count++;
    results();
  end
  // ----
  // monitor
  // ----
  always @(negedge sys_clk_in)
    if (rst_b_in && rsp.valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        bad_count++;
      else
      begin
        em = exp_q.pop_front();
        `CHK("result", em.rsp.result, rsp.result);
        `CHK("flags", {3'h0, em.flags}, flag_out);
        `CHK("mode", em.rsp.mode, rsp.mode);
        `CHK("addr", em.rsp.addr, rsp.addr);
      end
    end
endmodule
